/* File: bench/tb_paired_period_timer.sv */
// Self-checking testbench for the paired period timer block
`timescale 1ns/1ps
module tb_paired_period_timer
  import ptimer_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] wbAdr = 12'h000;
  logic [31:0] wbDatW = 32'h0;
  logic [3:0] wbSel = 4'h0;
  logic wbWe = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic [31:0] wbDatR;
  logic wbAck;
  logic wbErr;
  logic idleMode = 1'b0;
  logic [3:0] extPin = 4'h0;
  logic [3:0] gateIn = 4'h0;
  logic [3:0] periodMatch;
  logic irq;
  logic busErr;
  logic [31:0] rd;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  int n;

  paired_period_timer u_paired_period_timer (.clk(clk), .rst_n(rst_n), .wb_adr_i(wbAdr), .wb_dat_i(wbDatW),
    .wb_sel_i(wbSel), .wb_we_i(wbWe), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
    .wb_err_o(wbErr), .idleMode(idleMode), .externalTimerClockPin(extPin), .gateIn(gateIn),
    .periodMatch(periodMatch), .irq(irq));

  // 40 MHz clock
  initial begin
    forever #12.5 clk = ~clk;
  end

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  // Hang guard: the whole sequence needs about 1200 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One classic cycle; ack or err is sampled at the edge, the request drops only after it
  task automatic busCycle(input logic [11:0] a, input logic we, input logic [31:0] wd);
    @(posedge clk);
    wbAdr <= a;
    wbWe <= we;
    wbDatW <= wd;
    wbSel <= 4'hf;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    @(posedge clk iff (wbAck === 1'b1 || wbErr === 1'b1));
    rd = wbDatR;
    busErr = wbErr;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask : busCycle

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    busCycle(a, 1'b1, wd);
  endtask : wr

  task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
    busCycle(a, 1'b0, 32'h0);
    check(rd, exp);
  endtask : rdChk

  // Counts edges until the given match pulse is seen, bounded
  task automatic waitMatch(input int idx, output int cnt);
    cnt = 0;
    do begin
      @(posedge clk);
      cnt++;
    end while (periodMatch[idx] !== 1'b1 && cnt < 1000);
  endtask : waitMatch

  task automatic resetValues;
    logic [11:0] base;
    for (int t = 0; t < 4; t++) begin
      base = TIMER2_CONTROL_OFS + 12'(t * 32'h200);
      rdChk(base, {16'h0, CONTROL_RESET});
      rdChk(base + REG_STRIDE, {16'h0, COUNT_RESET});
      rdChk(base + 12'h020, {16'h0, PERIOD_RESET});
    end
    busCycle(12'h930, 1'b0, 32'h0);
    check(busErr, 1'b1);
  endtask : resetValues

  task automatic aliases;
    wr(12'h820, 32'hffff_1234);
    rdChk(12'h820, 32'h0000_1234);
    wr(12'h824, 32'h0000_0004);
    rdChk(12'h820, 32'h0000_1230);
    wr(12'h828, 32'h0000_00c0);
    rdChk(12'h820, 32'h0000_12f0);
    wr(12'h82c, 32'h0000_ff00);
    rdChk(12'h820, 32'h0000_edf0);
    wr(12'h800, 32'hffff_7f7d);
    rdChk(12'h800, 32'h0000_2078);
    wr(12'h804, 32'h0000_ffff);
    rdChk(12'h800, 32'h0);
    wr(12'ha00, 32'h0000_0008);
    rdChk(12'ha00, 32'h0);
  endtask : aliases

  // Period 3 gives a wrap every fourth tick; interrupt is masked, unmasked and cleared
  task automatic countAndIrq;
    wr(12'h820, 32'h3);
    wr(12'h810, 32'h0);
    wr(12'h800, 32'h8000);
    waitMatch(0, n);
    waitMatch(0, n);
    check(n, 4);
    wr(12'h800, 32'h0);
    rdChk(12'h900, 32'h1);
    check(irq, 1'b0);
    wr(12'h910, 32'h1);
    repeat (2) @(posedge clk);
    check(irq, 1'b1);
    wr(12'h900, 32'h1);
    repeat (2) @(posedge clk);
    check(irq, 1'b0);
    wr(12'h810, 32'h0);
    repeat (20) @(posedge clk);
    rdChk(12'h810, 32'h0);
  endtask : countAndIrq

  // Period 0 matches on every tick, so the pulse spacing equals the divisor
  task automatic prescaleCodes;
    int divs[8] = '{1, 2, 4, 8, 16, 32, 64, 256};
    wr(12'h820, 32'h0);
    for (int c = 0; c < 8; c++) begin
      wr(12'h800, 32'h8000 | (c << CTL_PRESCALE_LSB));
      waitMatch(0, n);
      waitMatch(0, n);
      check(n, divs[c]);
      wr(12'h800, 32'h0);
    end
  endtask : prescaleCodes

  task automatic joined;
    logic [31:0] held;
    wr(12'h900, 32'hf);
    wr(12'h820, 32'hffff);
    wr(12'ha10, 32'h0);
    wr(12'h810, 32'hfffe);
    wr(12'h800, 32'h8008);
    repeat (6) @(posedge clk);
    wr(12'h804, 32'h8000);
    rdChk(12'ha10, 32'h1);
    wr(12'ha10, 32'hffff);
    wr(12'h810, 32'hfffd);
    wr(12'h808, 32'h8000);
    waitMatch(1, n);
    check(n < 20, 1'b1);
    // Joined pair in idle: the odd stop-in-idle bit alone halts it, so software keeps it clear
    idleMode <= 1'b1;
    wr(12'ha08, 32'h2000);
    busCycle(12'h810, 1'b0, 32'h0);
    held = rd;
    repeat (10) @(posedge clk);
    rdChk(12'h810, held);
    wr(12'ha04, 32'h2000);
    repeat (10) @(posedge clk);
    busCycle(12'h810, 1'b0, 32'h0);
    check(rd != held, 1'b1);
    idleMode <= 1'b0;
    wr(12'h800, 32'h0);
    rdChk(12'h900, 32'h2);
  endtask : joined

  task automatic idleStop;
    wr(12'hc10, 32'h0);
    idleMode <= 1'b1;
    wr(12'hc00, 32'ha000);
    repeat (10) @(posedge clk);
    rdChk(12'hc10, 32'h0);
    wr(12'hc04, 32'h2000);
    repeat (10) @(posedge clk);
    busCycle(12'hc10, 1'b0, 32'h0);
    check(rd != 32'h0, 1'b1);
    idleMode <= 1'b0;
    wr(12'hc00, 32'h0);
  endtask : idleStop

  // Gate held low keeps the count, its falling edge raises the flag
  task automatic gated;
    wr(12'hc10, 32'h0);
    wr(12'h900, 32'hf);
    wr(12'hc00, 32'h8080);
    repeat (8) @(posedge clk);
    rdChk(12'hc10, 32'h0);
    gateIn[2] <= 1'b1;
    repeat (8) @(posedge clk);
    gateIn[2] <= 1'b0;
    waitMatch(2, n);
    check(n < 6, 1'b1);
    busCycle(12'hc10, 1'b0, 32'h0);
    check(rd != 32'h0, 1'b1);
    wr(12'hc00, 32'h0);
  endtask : gated

  task automatic external;
    wr(12'he00, 32'h808a);
    rdChk(12'he00, 32'h8002);
    wr(12'he10, 32'h0);
    repeat (5) begin
      @(posedge clk);
      extPin[3] <= 1'b1;
      repeat (2) @(posedge clk);
      extPin[3] <= 1'b0;
      @(posedge clk);
    end
    repeat (3) @(posedge clk);
    rdChk(12'he10, 32'h5);
  endtask : external

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    resetValues();
    aliases();
    countAndIrq();
    prescaleCodes();
    joined();
    idleStop();
    gated();
    external();
    test_done();
  end
endmodule : tb_paired_period_timer

/* File: hw/paired_period_timer.sv */
// Four period timers in two pairs, joinable to 32 bits, with a classic Wishbone slave
`timescale 1ns/1ps
module paired_period_timer
  import ptimer_pkg::*;
#(
  parameter int TIMERS = NUM_TIMERS
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic idleMode,
  input wire logic [TIMERS-1:0] externalTimerClockPin,
  input wire logic [TIMERS-1:0] gateIn,
  output logic [TIMERS-1:0] periodMatch,
  output logic irq
);
  logic [15:0] control_reg [TIMERS];
  logic [15:0] count_reg [TIMERS];
  logic [15:0] period_reg [TIMERS];
  logic [TIMERS-1:0] irqStatus_reg;
  logic [TIMERS-1:0] irqMask_reg;
  logic [TIMERS-1:0] extPrev_reg;
  logic [TIMERS-1:0] gatePrev_reg;
  logic [TIMERS-1:0] cntTick;
  logic [TIMERS-1:0] srcTick;
  logic [TIMERS-1:0] runOk;
  logic [TIMERS-1:0] wrapHit;
  logic [TIMERS-1:0] gateFall;
  logic [TIMERS-1:0] eventPulse;
  timer_ctl_s eff [TIMERS];
  bus_state_e busState_reg;
  logic busReq;
  logic busWrite;
  logic [1:0] aliasSel;
  logic [11:0] baseAdr;
  logic [31:0] wrMaskBits;
  logic [15:0] irqMaskAlias;

  // Extract control fields from a raw control word
  function automatic timer_ctl_s decode_ctl(input logic [15:0] c);
    timer_ctl_s d;
    d.enable = c[CTL_ENABLE_BIT];
    d.stopIdle = c[CTL_STOP_IDLE_BIT];
    d.gate = c[CTL_GATE_BIT];
    d.prescale = c[CTL_PRESCALE_LSB +: 3];
    d.pairJoinSelect = c[CTL_JOIN_BIT];
    d.clkSrc = c[CTL_CLKSRC_BIT];
    return d;
  endfunction : decode_ctl

  // Apply a plain, clear, set or invert write with byte enables
  function automatic logic [15:0] alias_write(input logic [15:0] old, input logic [15:0] data,
                                               input logic [1:0] sel, input logic [15:0] lanes);
    logic [15:0] r;
    r = old;
    case (sel)
      ALIAS_PLAIN: r = (old & ~lanes) | (data & lanes);
      ALIAS_CLR: r = old & ~(data & lanes);
      ALIAS_SET: r = old | (data & lanes);
      default: r = old ^ (data & lanes);
    endcase
    return r;
  endfunction : alias_write

  assign busReq = wb_cyc_i && wb_stb_i && (busState_reg == BUS_IDLE);
  assign busWrite = busReq && wb_we_i;
  assign aliasSel = wb_adr_i[3:2];
  assign baseAdr = {wb_adr_i[11:4], 4'h0};
  assign wrMaskBits = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  // Mask takes the alias forms; the whole function result is kept here and narrowed later
  assign irqMaskAlias = alias_write(16'(irqMask_reg), 16'(wb_dat_i[TIMERS-1:0]), aliasSel, wrMaskBits[15:0]);

  // Effective settings: joined odd timers take everything but stop-in-idle from the even one
  genvar g;
  generate
    for (g = 0; g < TIMERS; g++) begin : gen_timer
      localparam int EVEN = g & ~1;
      logic joined;
      timer_ctl_s own;
      timer_ctl_s lead;
      logic gatePin;
      logic gateOld;
      assign own = decode_ctl(control_reg[g]);
      assign lead = decode_ctl(control_reg[EVEN]);
      assign joined = lead.pairJoinSelect;
      always_comb begin
        eff[g] = own;
        if (joined && (g % 2 == 1)) begin
          eff[g] = lead;
          eff[g].stopIdle = own.stopIdle;
        end
      end
      // Either timer of a joined pair stopping in idle halts the pair
      assign runOk[g] = eff[g].enable && !(idleMode && (eff[g].stopIdle || (joined &&
                        control_reg[g ^ 1][CTL_STOP_IDLE_BIT])));
      // Source: pin rising edge, or every clock; gated mode needs the gate high
      assign srcTick[g] = eff[g].clkSrc ? (externalTimerClockPin[g] && !extPrev_reg[g])
                                        : (!eff[g].gate || gateIn[g]);
      // Joined pairs take the gate from the even pin and flag its fall on the odd timer only
      assign gatePin = (joined && (g % 2 == 1)) ? gateIn[EVEN] : gateIn[g];
      assign gateOld = (joined && (g % 2 == 1)) ? gatePrev_reg[EVEN] : gatePrev_reg[g];
      assign gateFall[g] = runOk[g] && !eff[g].clkSrc && eff[g].gate && gateOld && !gatePin &&
                           !(joined && (g % 2 == 0));
      ptimer_prescaler u_presc (
        .clk(clk),
        .rst_n(rst_n),
        .clear(!runOk[g]),
        .srcTick(srcTick[g] && runOk[g]),
        .prescale(eff[g].prescale),
        .tick(cntTick[g])
      );
    end
  endgenerate

  // Edge history of the external pins and gate inputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      extPrev_reg <= '0;
      gatePrev_reg <= '0;
    end else begin
      extPrev_reg <= externalTimerClockPin;
      gatePrev_reg <= gateIn;
    end
  end

  // Period compare, per pair so the joined case compares 32 bits
  always_comb begin
    for (int p = 0; p < TIMERS; p += 2) begin
      if (control_reg[p][CTL_JOIN_BIT]) begin
        wrapHit[p] = 1'b0;
        wrapHit[p+1] = cntTick[p] && ({count_reg[p+1], count_reg[p]} == {period_reg[p+1], period_reg[p]});
      end else begin
        wrapHit[p] = cntTick[p] && (count_reg[p] == period_reg[p]);
        wrapHit[p+1] = cntTick[p+1] && (count_reg[p+1] == period_reg[p+1]);
      end
    end
  end

  assign eventPulse = wrapHit | gateFall;

  // Counters; a bus write to a count register wins over the tick in that cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int t = 0; t < TIMERS; t++) begin
        count_reg[t] <= COUNT_RESET;
      end
    end else begin
      for (int p = 0; p < TIMERS; p += 2) begin
        if (control_reg[p][CTL_JOIN_BIT]) begin
          if (cntTick[p]) begin
            {count_reg[p+1], count_reg[p]} <= wrapHit[p+1] ? 32'h0 :
                                              {count_reg[p+1], count_reg[p]} + 32'h1;
          end
        end else begin
          for (int k = p; k < p + 2; k++) begin
            if (cntTick[k]) begin
              count_reg[k] <= wrapHit[k] ? 16'h0000 : count_reg[k] + 16'h0001;
            end
          end
        end
      end
      for (int t = 0; t < TIMERS; t++) begin
        if (busWrite && baseAdr == TIMER2_COUNT_OFS + TIMER_BLOCK_STRIDE * 12'(t)) begin
          count_reg[t] <= alias_write(count_reg[t], wb_dat_i[15:0], aliasSel, wrMaskBits[15:0]);
        end
      end
    end
  end

  // Control and period registers written from the bus
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int t = 0; t < TIMERS; t++) begin
        control_reg[t] <= CONTROL_RESET;
        period_reg[t] <= PERIOD_RESET;
      end
    end else if (busWrite) begin
      for (int t = 0; t < TIMERS; t++) begin
        if (baseAdr == TIMER2_CONTROL_OFS + TIMER_BLOCK_STRIDE * 12'(t)) begin
          control_reg[t] <= alias_write(control_reg[t], wb_dat_i[15:0], aliasSel, wrMaskBits[15:0]) &
                            ((t % 2 == 0) ? CTL_MASK_EVEN : CTL_MASK_ODD);
        end
        if (baseAdr == TIMER2_PERIOD_OFS + TIMER_BLOCK_STRIDE * 12'(t)) begin
          period_reg[t] <= alias_write(period_reg[t], wb_dat_i[15:0], aliasSel, wrMaskBits[15:0]);
        end
      end
    end
  end

  // Sticky status: a hardware event in the same cycle as a clear keeps its bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStatus_reg <= '0;
      irqMask_reg <= '0;
    end else begin
      if (busWrite && baseAdr == IRQ_STATUS_OFS) begin
        irqStatus_reg <= (irqStatus_reg & ~(wb_dat_i[TIMERS-1:0] & wrMaskBits[TIMERS-1:0])) | eventPulse;
      end else begin
        irqStatus_reg <= irqStatus_reg | eventPulse;
      end
      if (busWrite && baseAdr == IRQ_MASK_OFS) begin
        irqMask_reg <= irqMaskAlias[TIMERS-1:0];
      end
    end
  end

  // Registered outputs: match pulses and the level interrupt
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      periodMatch <= '0;
      irq <= 1'b0;
    end else begin
      periodMatch <= eventPulse;
      irq <= |(irqStatus_reg & irqMask_reg);
    end
  end

  // Read value: gate bit shows zero while the external clock is selected
  function automatic logic [31:0] read_word(input logic [11:0] a);
    logic [31:0] v;
    v = 32'h0;
    for (int t = 0; t < TIMERS; t++) begin
      if (a == TIMER2_CONTROL_OFS + TIMER_BLOCK_STRIDE * 12'(t)) begin
        v[15:0] = control_reg[t];
        if (control_reg[t][CTL_CLKSRC_BIT]) begin
          v[CTL_GATE_BIT] = 1'b0;
        end
      end else if (a == TIMER2_COUNT_OFS + TIMER_BLOCK_STRIDE * 12'(t)) begin
        v[15:0] = count_reg[t];
      end else if (a == TIMER2_PERIOD_OFS + TIMER_BLOCK_STRIDE * 12'(t)) begin
        v[15:0] = period_reg[t];
      end
    end
    if (a == IRQ_STATUS_OFS) begin
      v[TIMERS-1:0] = irqStatus_reg;
    end else if (a == IRQ_MASK_OFS) begin
      v[TIMERS-1:0] = irqMask_reg;
    end
    return v;
  endfunction : read_word

  // Is the base address one of ours; unmapped accesses get err instead of ack
  function automatic logic mapped(input logic [11:0] a);
    logic m;
    m = (a == IRQ_STATUS_OFS) || (a == IRQ_MASK_OFS);
    for (int t = 0; t < TIMERS; t++) begin
      for (int r = 0; r < NUM_REGS; r++) begin
        if (a == TIMER2_CONTROL_OFS + TIMER_BLOCK_STRIDE * 12'(t) + REG_STRIDE * 12'(r)) begin
          m = 1'b1;
        end
      end
    end
    return m;
  endfunction : mapped

  // Wishbone slave: one wait state, answer one cycle after the request is seen, then a gap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busState_reg <= BUS_IDLE;
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      case (busState_reg)
        BUS_IDLE: begin
          if (busReq) begin
            busState_reg <= BUS_ACK;
            wb_ack_o <= mapped(baseAdr);
            wb_err_o <= !mapped(baseAdr);
            wb_dat_o <= wb_we_i ? 32'h0 : read_word(baseAdr);
          end
        end
        default: begin
          busState_reg <= BUS_IDLE;
        end
      endcase
    end
  end

  // Answer arrives exactly one edge after the request was taken
  chk_bus_answer: assert property (@(posedge clk) disable iff (!rst_n)
    busReq |=> (wb_ack_o || wb_err_o)) else $error("bus request not answered");
  // Disabled timer never advances its counter
  chk_disabled_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (!runOk[0] && !control_reg[0][CTL_JOIN_BIT] && !busWrite) |=> $stable(count_reg[0]))
    else $error("disabled timer counted");
  // Idle with stop-in-idle halts the timer
  chk_idle_stop: assert property (@(posedge clk) disable iff (!rst_n)
    (idleMode && eff[0].stopIdle) |-> !runOk[0]) else $error("timer ran in idle");
  // Gate bit reads zero with external source
  chk_gate_read: assert property (@(posedge clk) disable iff (!rst_n)
    (busReq && !wb_we_i && baseAdr == TIMER2_CONTROL_OFS && control_reg[0][CTL_CLKSRC_BIT])
    |=> !wb_dat_o[CTL_GATE_BIT]) else $error("gate bit visible with external clock");
  // Odd timer has no join bit and no bits 12..8
  chk_odd_join: assert property (@(posedge clk) disable iff (!rst_n)
    control_reg[1][CTL_JOIN_BIT] == 1'b0 && control_reg[1][12:8] == 5'h0)
    else $error("odd join bit set");
  // A period match wraps the counter to zero and flags the next cycle
  chk_wrap_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (wrapHit[0] && !busWrite) |=> (count_reg[0] == 16'h0000 && irqStatus_reg[0] && periodMatch[0]))
    else $error("period match did not wrap");
  // Joined pair never flags the even timer on a wrap
  chk_join_flag: assert property (@(posedge clk) disable iff (!rst_n)
    control_reg[0][CTL_JOIN_BIT] |-> !eventPulse[0]) else $error("joined even timer flagged");
  // Even control never holds a bit outside its implemented set
  chk_ctl_unimpl: assert property (@(posedge clk) disable iff (!rst_n)
    (control_reg[0] & ~CTL_MASK_EVEN) == 16'h0000) else $error("unimplemented control bit set");
  // Interrupt follows unmasked status one cycle later
  chk_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
    |(irqStatus_reg & irqMask_reg) |=> irq) else $error("interrupt not raised");
  // Period reset value of timer 0 right after reset is released
  chk_period_init: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> period_reg[0] == PERIOD_RESET) else $error("period reset value wrong");
endmodule : paired_period_timer

/* File: hw/ptimer_pkg.sv */
// Package: register map, field positions, reset values and types of the paired period timer
package ptimer_pkg;
  localparam int NUM_TIMERS = 4;
  localparam int NUM_REGS = 3;
  // Byte offsets of the timer registers
  localparam logic [11:0] TIMER2_CONTROL_OFS = 12'h800;
  localparam logic [11:0] TIMER2_COUNT_OFS = 12'h810;
  localparam logic [11:0] TIMER2_PERIOD_OFS = 12'h820;
  localparam logic [11:0] TIMER3_CONTROL_OFS = 12'ha00;
  localparam logic [11:0] TIMER3_COUNT_OFS = 12'ha10;
  localparam logic [11:0] TIMER3_PERIOD_OFS = 12'ha20;
  localparam logic [11:0] TIMER4_CONTROL_OFS = 12'hc00;
  localparam logic [11:0] TIMER4_COUNT_OFS = 12'hc10;
  localparam logic [11:0] TIMER4_PERIOD_OFS = 12'hc20;
  localparam logic [11:0] TIMER5_CONTROL_OFS = 12'he00;
  localparam logic [11:0] TIMER5_COUNT_OFS = 12'he10;
  localparam logic [11:0] TIMER5_PERIOD_OFS = 12'he20;
  localparam logic [11:0] TIMER_BLOCK_STRIDE = 12'h200;
  localparam logic [11:0] REG_STRIDE = 12'h010;
  // Interrupt status and mask registers
  localparam logic [11:0] IRQ_STATUS_OFS = 12'h900;
  localparam logic [11:0] IRQ_MASK_OFS = 12'h910;
  // Alias sub-offsets: plain, clear, set, invert
  localparam logic [1:0] ALIAS_PLAIN = 2'h0;
  localparam logic [1:0] ALIAS_CLR = 2'h1;
  localparam logic [1:0] ALIAS_SET = 2'h2;
  localparam logic [1:0] ALIAS_INV = 2'h3;
  // Control field positions
  localparam int CTL_ENABLE_BIT = 15;
  localparam int CTL_STOP_IDLE_BIT = 13;
  localparam int CTL_GATE_BIT = 7;
  localparam int CTL_PRESCALE_LSB = 4;
  localparam int CTL_JOIN_BIT = 3;
  localparam int CTL_CLKSRC_BIT = 1;
  // Writable bits of even and odd control registers
  localparam logic [15:0] CTL_MASK_EVEN = 16'ha0fa;
  localparam logic [15:0] CTL_MASK_ODD = 16'ha0f2;
  // Reset values
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'hffff;

  typedef struct packed {
    logic enable;
    logic stopIdle;
    logic gate;
    logic [2:0] prescale;
    logic pairJoinSelect;
    logic clkSrc;
  } timer_ctl_s;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK = 2'b01
  } bus_state_e;
endpackage : ptimer_pkg

/* File: hw/ptimer_prescaler.sv */
// Prescaler: turns source ticks into counter ticks at 1:1 .. 1:256
`timescale 1ns/1ps
module ptimer_prescaler
  import ptimer_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic srcTick,
  input wire logic [2:0] prescale,
  output logic tick
);
  logic [7:0] divCount_reg;
  logic [7:0] divLimit;

  // Code to terminal count: 1,2,4,8,16,32,64,256
  always_comb begin
    case (prescale)
      3'h0: divLimit = 8'h00;
      3'h1: divLimit = 8'h01;
      3'h2: divLimit = 8'h03;
      3'h3: divLimit = 8'h07;
      3'h4: divLimit = 8'h0f;
      3'h5: divLimit = 8'h1f;
      3'h6: divLimit = 8'h3f;
      default: divLimit = 8'hff;
    endcase
  end

  // Divider restarts when the timer is stopped so a restart begins a full interval
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divCount_reg <= 8'h00;
    end else if (clear) begin
      divCount_reg <= 8'h00;
    end else if (srcTick) begin
      divCount_reg <= (divCount_reg >= divLimit) ? 8'h00 : divCount_reg + 8'h01;
    end
  end

  assign tick = srcTick && (divCount_reg >= divLimit);
endmodule : ptimer_prescaler
